//--- srs_pkg.sv
// Constants and types shared by the reset and sleep control block.
package srs_pkg;
  // Register byte offsets.
  localparam logic [3:0] SRS_ARC_OFF = 4'h0;
  localparam logic [3:0] SRS_SCW_OFF = 4'h4;
  localparam logic [3:0] SRS_STA_OFF = 4'h8;
  // Bit positions in app_reset_control_word.
  localparam int SRS_ARC_CLR_BIT = 0;
  localparam int SRS_ARC_SYS_BIT = 1;
  localparam int SRS_ARC_LOC_BIT = 2;
  // Bit positions in sleep_control_word.
  localparam int SRS_SCW_EXIT_BIT = 1;
  localparam int SRS_SCW_DEEP_BIT = 2;
  localparam int SRS_SCW_PEND_BIT = 4;
  localparam int SRS_SCW_NOP_BIT  = 5;
  // Status word field positions.
  localparam int SRS_STA_ACT_BIT = 9;
  localparam int SRS_STA_EVT_BIT = 12;
  localparam int SRS_STA_SLP_BIT = 13;
  localparam int SRS_STA_ST_LSB  = 14;
  // Reset values.
  localparam logic [7:0] SRS_SCW_RST = 8'h00;
  // AXI responses.
  localparam logic [1:0] SRS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SRS_RESP_SLVERR = 2'h2;
  // Sleep state machine.
  typedef enum logic [1:0] {
    SRS_RUN      = 2'b00,
    SRS_WAIT_INT = 2'b01,
    SRS_WAIT_EVT = 2'b10,
    SRS_EXIT     = 2'b11
  } srs_state_e;
endpackage

//--- srs_reset_sleep.sv
// Reset request, clear-active and sleep control with an AXI4-Lite slave.
`timescale 1ns/1ps
module srs_reset_sleep
  import srs_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data.
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response.
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read.
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Core hints and exception state.
  input  wire logic        wait_interrupt_hint,
  input  wire logic        wait_event_hint,
  input  wire logic        send_event_hint,
  input  wire logic        exc_return,
  input  wire logic        exc_entry,
  input  wire logic        other_active,
  input  wire logic [8:0]  exc_number,
  input  wire logic        any_active,
  // Wakeup sources.
  input  wire logic        irq_new_pending,
  input  wire logic        exc_new_pending,
  input  wire logic        exc_would_preempt,
  input  wire logic        debug_event,
  input  wire logic        debug_enable,
  input  wire logic        impl_wakeup,
  input  wire logic        remote_send_event,
  // Core control outputs.
  output logic             hint_done,
  output logic             tail_chain,
  output logic             clear_all_active,
  output logic             send_event_out,
  // Reset outputs.
  output logic             system_reset_request,
  output logic             local_core_reset,
  output logic             debug_full_reset,
  output logic             debug_part_reset,
  // Power controller.
  output logic             sleeping,
  output logic             deep_sleep
);

  // State and register storage.
  srs_state_e  st_reg, st_next;
  logic        aw_have_reg, w_have_reg;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [7:0]  scw_reg;
  logic        event_reg, cleared_reg;
  logic        event_next;

  // Write channel decode.
  wire aw_take = awvalid && awready;
  wire w_take  = wvalid && wready;
  wire do_wr   = aw_have_reg && w_have_reg && !bvalid;
  wire aw_have_next = aw_take || (aw_have_reg && !do_wr);
  wire w_have_next  = w_take || (w_have_reg && !do_wr);
  wire hit_arc = do_wr && (aw_addr_reg == SRS_ARC_OFF);
  wire hit_scw = do_wr && (aw_addr_reg == SRS_SCW_OFF);
  wire wr_ok   = hit_arc || hit_scw || (aw_addr_reg == SRS_STA_OFF);
  wire lane0   = w_strb_reg[0];
  wire wr_clr  = hit_arc && lane0 && w_data_reg[SRS_ARC_CLR_BIT];
  wire wr_sys  = hit_arc && lane0 && w_data_reg[SRS_ARC_SYS_BIT];
  wire wr_loc  = hit_arc && lane0 && w_data_reg[SRS_ARC_LOC_BIT]
                 && !w_data_reg[SRS_ARC_SYS_BIT];

  // Read channel decode.
  wire ar_take = arvalid && arready;
  wire rvalid_next = ar_take || (rvalid && !rready);
  wire [9:0] exc_view = cleared_reg ? 10'h000 : {any_active, exc_number};
  wire [31:0] sta_word = {16'h0000, st_reg, sleeping, event_reg, 2'h0,
                          exc_view};
  wire [31:0] rd_word = (araddr == SRS_ARC_OFF) ?
                          {30'h0, system_reset_request, 1'h0} :
                        (araddr == SRS_SCW_OFF) ? {24'h000000, scw_reg} :
                        sta_word;
  wire rd_ok = (araddr == SRS_ARC_OFF) || (araddr == SRS_SCW_OFF)
               || (araddr == SRS_STA_OFF);

  // Configuration fields.
  wire cfg_exit = scw_reg[SRS_SCW_EXIT_BIT];
  wire cfg_deep = scw_reg[SRS_SCW_DEEP_BIT];
  wire cfg_pend = scw_reg[SRS_SCW_PEND_BIT];
  wire cfg_nop  = scw_reg[SRS_SCW_NOP_BIT];

  // Wakeup event sets; the priority mask bit never enters here.
  wire dbg_wake  = debug_enable && debug_event;
  wire wint_wake = exc_would_preempt || dbg_wake || impl_wakeup;
  wire send_here = send_event_hint && !cfg_nop;
  wire pend_wake = cfg_pend
                   && (irq_new_pending || exc_new_pending);
  wire wevt_wake = remote_send_event || send_here || pend_wake
                   || exc_would_preempt || dbg_wake;
  wire in_run    = (st_reg == SRS_RUN);
  wire wevt_now  = in_run && wait_event_hint && !cfg_nop;
  wire wint_now  = in_run && wait_interrupt_hint && !cfg_nop;
  wire exit_now  = in_run && exc_return && cfg_exit && !other_active;
  wire wevt_fast = wevt_now && (event_reg || wevt_wake);
  wire nop_hint  = in_run && cfg_nop
                   && (wait_event_hint || wait_interrupt_hint);

  // Sleep state machine next state.
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      SRS_RUN: begin
        if (wint_now && !wint_wake) begin
          st_next = SRS_WAIT_INT;
        end else if (wevt_now && !wevt_fast) begin
          st_next = SRS_WAIT_EVT;
        end else if (exit_now) begin
          st_next = SRS_EXIT;
        end
      end
      SRS_WAIT_INT: if (wint_wake) st_next = SRS_RUN;
      SRS_WAIT_EVT: if (wevt_wake) st_next = SRS_RUN;
      SRS_EXIT:     if (wint_wake) st_next = SRS_RUN;
    endcase
  end

  // Event latch: a set in the same cycle as a clear wins.
  always_comb begin
    event_next = event_reg;
    if (wevt_now) begin
      event_next = 1'b0;
    end
    if (wevt_wake || exc_return) begin
      event_next = 1'b1;
    end
  end

  // AXI handshake state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      arready     <= 1'b0;
      rvalid      <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      awready     <= !aw_have_next;
      wready      <= !w_have_next;
      bvalid      <= do_wr || (bvalid && !bready);
      arready     <= !rvalid_next;
      rvalid      <= rvalid_next;
    end
  end

  // AXI payload capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 4'h0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bresp       <= SRS_RESP_OKAY;
      rdata       <= 32'h00000000;
      rresp       <= SRS_RESP_OKAY;
    end else begin
      if (aw_take) aw_addr_reg <= awaddr;
      if (w_take) w_data_reg <= wdata;
      if (w_take) w_strb_reg <= wstrb;
      if (do_wr) bresp <= wr_ok ? SRS_RESP_OKAY : SRS_RESP_SLVERR;
      if (ar_take) rdata <= rd_ok ? rd_word : 32'h00000000;
      if (ar_take) rresp <= rd_ok ? SRS_RESP_OKAY : SRS_RESP_SLVERR;
    end
  end

  // Reset requests; the system request holds until the reset arrives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset_request <= 1'b0;
      local_core_reset     <= 1'b0;
      debug_full_reset     <= 1'b1;
      debug_part_reset     <= 1'b0;
    end else begin
      system_reset_request <= system_reset_request || wr_sys;
      local_core_reset     <= system_reset_request || wr_sys
                              || wr_loc;
      debug_full_reset     <= 1'b0;
      debug_part_reset     <= wr_loc;
    end
  end

  // Clear-all-active pulse; pending state is never driven from here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_all_active <= 1'b0;
      cleared_reg      <= 1'b0;
    end else begin
      clear_all_active <= wr_clr;
      cleared_reg      <= wr_clr || (cleared_reg && !exc_entry);
    end
  end

  // Configuration register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scw_reg <= SRS_SCW_RST;
    end else if (hit_scw && lane0) begin
      scw_reg <= w_data_reg[7:0];
    end
  end

  // Sleep state, event latch and core-facing pulses.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg         <= SRS_RUN;
      event_reg      <= 1'b0;
      hint_done      <= 1'b0;
      tail_chain     <= 1'b0;
      send_event_out <= 1'b0;
      sleeping       <= 1'b0;
      deep_sleep     <= 1'b0;
    end else begin
      st_reg         <= st_next;
      event_reg      <= event_next;
      hint_done      <= nop_hint || (wint_now && wint_wake) || wevt_fast
                        || (st_reg == SRS_WAIT_INT && wint_wake)
                        || (st_reg == SRS_WAIT_EVT && wevt_wake);
      tail_chain     <= (st_reg == SRS_EXIT) && wint_wake;
      send_event_out <= send_here;
      sleeping       <= (st_next != SRS_RUN);
      deep_sleep     <= (st_next != SRS_RUN) && cfg_deep;
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sys_req;
    wr_sys |=> system_reset_request && local_core_reset;
  endproperty
  a_sys_req: assert property (p_sys_req) else $error("sys req lost");
  property p_sys_local;
    system_reset_request |=> local_core_reset;
  endproperty
  a_sys_local: assert property (p_sys_local) else $error("no local");
  property p_loc_reset;
    wr_loc |=> local_core_reset && debug_part_reset ##1 !debug_part_reset;
  endproperty
  a_loc_reset: assert property (p_loc_reset) else $error("loc rst");
  property p_clear;
    wr_clr |=> clear_all_active && exc_view == 10'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear fail");
  property p_cleared_zero;
    cleared_reg && !exc_entry |=> sta_word[SRS_STA_ACT_BIT:0] == 10'h000;
  endproperty
  a_cleared_zero: assert property (p_cleared_zero) else $error("nz");
  property p_latch_set;
    wevt_wake || exc_return |=> event_reg;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch");
  property p_pend_wake;
    st_reg == SRS_WAIT_EVT && cfg_pend && irq_new_pending
      |=> st_reg == SRS_RUN && hint_done;
  endproperty
  a_pend_wake: assert property (p_pend_wake) else $error("pend");
  property p_wevt_fast;
    wevt_now && event_reg && !wevt_wake && !exc_return
      |=> hint_done && st_reg == SRS_RUN && !event_reg;
  endproperty
  a_wevt_fast: assert property (p_wevt_fast) else $error("fast");
  property p_exit_sleep;
    exit_now && !wint_now && !wevt_now
      |=> st_reg == SRS_EXIT && sleeping;
  endproperty
  a_exit_sleep: assert property (p_exit_sleep) else $error("exit");
  property p_exit_wake;
    st_reg == SRS_EXIT && exc_would_preempt |=> tail_chain && !sleeping;
  endproperty
  a_exit_wake: assert property (p_exit_wake) else $error("wake");
  property p_deep;
    deep_sleep |-> sleeping && $past(cfg_deep);
  endproperty
  a_deep: assert property (p_deep) else $error("deep");
  property p_send;
    send_here |=> send_event_out && event_reg;
  endproperty
  a_send: assert property (p_send) else $error("send");

  c_wint_sleep: cover property (wint_now && !wint_wake ##[1:20] hint_done);
  c_wevt_sleep: cover property (st_reg == SRS_WAIT_EVT ##[1:20] in_run);
  c_exit_chain: cover property (exit_now ##[1:20] tail_chain);
  c_sys_reset: cover property (wr_sys);

endmodule

//--- srs_power_partner.sv
// Behavioural model of the external reset and power controller.
`timescale 1ns/1ps
module srs_power_partner #(
  parameter int DLY = 8,
  parameter int LEN = 3
) (
  // Clock.
  input  wire logic aclk,
  // Requests from the block.
  input  wire logic system_reset_request,
  input  wire logic sleeping,
  input  wire logic deep_sleep,
  // Answers to the system.
  output logic      sys_rst_n,
  output logic      clk_source_off
);
  int cnt = 0;
  // A request starts a late reset pulse of LEN cycles.
  always @(posedge aclk) begin
    if (cnt != 0 || system_reset_request) begin
      cnt <= (cnt == DLY + LEN) ? 0 : cnt + 1;
    end
  end
  assign sys_rst_n = !(cnt > DLY);
  // The clock source may stop only in deep sleep.
  assign clk_source_off = sleeping & deep_sleep;
endmodule

//--- tb_srs_reset_sleep.sv
// Self-checking testbench for the reset and sleep control block.
`timescale 1ns/1ps
module tb_srs_reset_sleep import srs_pkg::*;;
  logic        aclk = '0, rst_b = '0, awvalid = '0, wvalid = '0;
  logic        bready = '0, arvalid = '0, rready = '0, debug_enable = '0;
  logic        other_active = '0, any_active = '0;
  logic [3:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [8:0]  exc_number = '0;
  logic [10:0] ev = '0;
  logic        awready, wready, bvalid, arready, rvalid, sys_rst_n;
  logic        hint_done, tail_chain, clear_all_active, send_event_out;
  logic        system_reset_request, local_core_reset, debug_full_reset;
  logic        debug_part_reset, sleeping, deep_sleep, clk_source_off;
  logic [1:0]  bresp, rresp, resp;
  int          fails = 0, cmp_count = 0, pc[6] = '{default: 0}, c[6];

  // Free-running core clock.
  always #25 aclk = ~aclk;

  srs_reset_sleep DUT (
    .aclk(aclk), .aresetn(rst_b & sys_rst_n), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wait_interrupt_hint(ev[0]), .wait_event_hint(ev[1]),
    .send_event_hint(ev[2]), .exc_return(ev[3]), .exc_entry(ev[4]),
    .other_active(other_active), .exc_number(exc_number),
    .any_active(any_active), .irq_new_pending(ev[5]),
    .exc_new_pending(ev[6]), .exc_would_preempt(ev[7]),
    .debug_event(ev[8]), .debug_enable(debug_enable),
    .impl_wakeup(ev[9]), .remote_send_event(ev[10]),
    .hint_done(hint_done), .tail_chain(tail_chain),
    .clear_all_active(clear_all_active), .send_event_out(send_event_out),
    .system_reset_request(system_reset_request),
    .local_core_reset(local_core_reset),
    .debug_full_reset(debug_full_reset),
    .debug_part_reset(debug_part_reset), .sleeping(sleeping),
    .deep_sleep(deep_sleep));

  srs_power_partner PART (
    .aclk(aclk), .system_reset_request(system_reset_request),
    .sleeping(sleeping), .deep_sleep(deep_sleep), .sys_rst_n(sys_rst_n),
    .clk_source_off(clk_source_off));

  // Counts the one-cycle pulses so that no pulse is missed.
  always @(posedge aclk) begin
    if (hint_done === '1) pc[0]++;
    if (tail_chain === '1) pc[1]++;
    if (clear_all_active === '1) pc[2]++;
    if (send_event_out === '1) pc[3]++;
    if (local_core_reset === '1) pc[4]++;
    if (debug_part_reset === '1) pc[5]++;
  end

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One write; address and data offered together, each let go when taken.
  task automatic axw(logic [3:0] a, logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awvalid <= '1;
    awaddr <= a;
    wvalid <= '1;
    wdata <= d;
    bready <= '1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= '0;
      if (wvalid && wready) wvalid <= '0;
    end while (!(bvalid && bready) && n < 40);
    resp = bresp;
    bready <= '0;
    if (n >= 40) fails++;
  endtask

  // One read; data and response are taken at the rvalid edge.
  task automatic axr(logic [3:0] a);
    int n = 0;
    @(posedge aclk);
    arvalid <= '1;
    araddr <= a;
    rready <= '1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= '0;
    end while (!(rvalid && rready) && n < 40);
    rd = rdata;
    resp = rresp;
    rready <= '0;
    if (n >= 40) fails++;
  endtask

  task automatic pulse(logic [10:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= '0;
  endtask

  // Enters sleep with hint h, checks the state, then wakes it with w.
  task automatic sw(logic [10:0] h, logic [10:0] w, int k, logic [1:0] st);
    pulse(h);
    axr(SRS_STA_OFF);
    chk("sleeping", sleeping, 1);
    chk("state", rd[15:14], st);
    c = pc;
    pulse(w);
    repeat (3) @(posedge aclk);
    chk("wake", pc[k] - c[k], 1);
    chk("awake", sleeping, 0);
  endtask

  task automatic t_map();
    chk("dbg_full", debug_full_reset, 0);
    axr(SRS_STA_OFF);
    chk("status", rd, 0);
    axw(4'hc, 32'h1);
    chk("bresp", resp, SRS_RESP_SLVERR);
    axr(4'hc);
    chk("rresp", resp, SRS_RESP_SLVERR);
    chk("rdata", rd, 32'h0);
    axw(SRS_SCW_OFF, 32'h16);
    chk("bresp_ok", resp, SRS_RESP_OKAY);
    axr(SRS_SCW_OFF);
    chk("scw", rd, 32'h16);
  endtask

  task automatic t_reset();
    exc_number <= 9'h0a5;
    any_active <= '1;
    c = pc;
    axw(SRS_ARC_OFF, 32'h1);
    @(posedge aclk);
    chk("clr", pc[2] - c[2], 1);
    axr(SRS_STA_OFF);
    chk("exc_num", rd[9:0], 10'h000);
    pulse(11'h010);
    axr(SRS_STA_OFF);
    chk("exc_num", rd[9:0], 10'h2a5);
    c = pc;
    axw(SRS_ARC_OFF, 32'h4);
    @(posedge aclk);
    chk("loc_rst", pc[4] - c[4], 1);
    chk("dbg_part", pc[5] - c[5], 1);
    chk("sys_req", system_reset_request, 0);
  endtask

  task automatic t_wait_int();
    logic [10:0] ws[3] = '{11'h080, 11'h100, 11'h200};
    axw(SRS_SCW_OFF, 32'h4);
    pulse(11'h001);
    repeat (2) @(posedge aclk);
    chk("deep", deep_sleep, 1);
    chk("clk_off", clk_source_off, 1);
    pulse(11'h100);
    repeat (2) @(posedge aclk);
    chk("dbg_off", sleeping, 1);
    debug_enable <= '1;
    pulse(11'h080);
    repeat (3) @(posedge aclk);
    chk("deep_off", deep_sleep, 0);
    foreach (ws[i]) sw(11'h001, ws[i], 0, 2'h1);
  endtask

  task automatic t_wait_evt();
    logic [10:0] ws[5] = '{11'h400, 11'h020, 11'h040, 11'h080, 11'h100};
    axw(SRS_SCW_OFF, 32'h10);
    c = pc;
    pulse(11'h004);
    repeat (3) @(posedge aclk);
    chk("send_out", pc[3] - c[3], 1);
    axr(SRS_STA_OFF);
    chk("latch", rd[12], 1);
    c = pc;
    pulse(11'h002);
    repeat (3) @(posedge aclk);
    chk("evt_fast", pc[0] - c[0], 1);
    axr(SRS_STA_OFF);
    chk("latch", rd[13:12], 2'h0);
    foreach (ws[i]) begin
      sw(11'h002, ws[i], 0, 2'h2);
      pulse(11'h002);
      repeat (3) @(posedge aclk);
    end
    axw(SRS_SCW_OFF, 32'h0);
    pulse(11'h002);
    pulse(11'h060);
    repeat (2) @(posedge aclk);
    chk("no_pend", sleeping, 1);
    pulse(11'h400);
    pulse(11'h002);
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_exit();
    logic [10:0] ws[3] = '{11'h080, 11'h100, 11'h200};
    axw(SRS_SCW_OFF, 32'h2);
    other_active <= '1;
    pulse(11'h008);
    axr(SRS_STA_OFF);
    chk("busy_ret", rd[13:12], 2'h1);
    other_active <= '0;
    foreach (ws[i]) sw(11'h008, ws[i], 1, 2'h3);
    axw(SRS_SCW_OFF, 32'h20);
    c = pc;
    pulse(11'h001);
    repeat (3) @(posedge aclk);
    chk("nop", pc[0] - c[0], 1);
    chk("nop_awake", sleeping, 0);
  endtask

  task automatic t_sys();
    axw(SRS_ARC_OFF, 32'h2);
    chk("sys_req", {system_reset_request, local_core_reset}, 2'h3);
    axr(SRS_ARC_OFF);
    chk("arc", rd[1], 1);
    repeat (16) @(posedge aclk);
    chk("sys_req", system_reset_request, 0);
    axr(SRS_SCW_OFF);
    chk("scw_rst", rd, 0);
  endtask

  // Main sequence.
  initial begin
    repeat (8) @(posedge aclk);
    chk("dbg_full", debug_full_reset, 1);
    rst_b <= '1;
    repeat (2) @(posedge aclk);
    t_map();
    t_reset();
    t_wait_int();
    t_wait_evt();
    t_exit();
    t_sys();
    tally_and_finish();
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end
endmodule
